/* hdl/plc_pkg.sv */
// constants for the pll control and periodic rate divider block
// assumes one 25 MHz clock and a byte-wide register port
package plc_pkg;

  // ****************
  // register map
  // ****************
  localparam int ADDR_W = 4;
  localparam logic [3:0] PLL_CTRL_OFS = 4'h6;
  localparam logic [3:0] RATE_CTRL_OFS = 4'h7;

  // ****************
  // field positions
  // ****************
  localparam int CME_BIT = 7;
  localparam int PLL_POWER_ON_BIT = 6;
  localparam int AUTO_BIT = 5;
  localparam int ACQ_BIT = 4;
  localparam int RSVD_BIT = 3;
  localparam int PRE_BIT = 2;
  localparam int PCE_BIT = 1;
  localparam int SELF_CLOCK_ON_FAIL_ENABLE_BIT = 0;
  localparam int PRESC_LSB = 4;
  localparam int PRESC_W = 3;
  localparam int MODUL_LSB = 0;
  localparam int MODUL_W = 4;

  // ****************
  // reset values
  // ****************
  localparam logic [7:0] PLL_CTRL_RST = 8'hF1;
  localparam logic [6:0] RATE_CTRL_RST = 7'h00;

  // ****************
  // timing
  // ****************
  localparam int PRESC_BASE_EXP = 9;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MON_TIMEOUT_NS = 4000;
  localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************
  // clock monitor states
  // ****************
  typedef enum logic [2:0] {
    PLC_MON_OFF = 3'h1,
    PLC_MON_WATCH = 3'h2,
    PLC_MON_FAIL = 3'h4
  } plc_mon_e;

endpackage : plc_pkg

/* hdl/plc_rti_if.sv */
// signals between the control registers and the periodic divider
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface plc_rti_if;
  logic [2:0] prescale;
  logic [3:0] modulus;
  logic restart;
  logic osc_tick;
  logic hold;
  logic tick;

  modport ctrl (output prescale, output modulus, output restart,
                output osc_tick, output hold, input tick);
  modport div (input prescale, input modulus, input restart,
               input osc_tick, input hold, output tick);
endinterface : plc_rti_if
`default_nettype wire

/* hdl/plc_rti_divider.sv */
// periodic divider chain: prescaler times modulus, on oscillator ticks
// assumes osc_tick is already synchronised to i_clock
`timescale 1ns/1ps
`default_nettype none
module plc_rti_divider #(
  parameter int PRE_W = 16
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clock_en,
  plc_rti_if.div rti
);

  if (PRE_W != plc_pkg::PRESC_BASE_EXP + 7) begin : g_chk
    $error("prescaler width must match the largest prescale factor");
  end

  logic [PRE_W-1:0] pre_cnt_q;
  logic [3:0] mod_cnt_q;
  logic tick_q;
  logic pre_last;

  function automatic logic [PRE_W-1:0] pre_top(input logic [2:0] p);
    logic [PRE_W:0] one;
    logic [4:0] sh;
    one = (PRE_W+1)'(1);
    sh = 5'(plc_pkg::PRESC_BASE_EXP) + 5'(p);
    pre_top = PRE_W'((one << sh) - one);
  endfunction : pre_top

  assign pre_last = (pre_cnt_q == pre_top(rti.prescale));
  assign rti.tick = tick_q;

  // ****************
  // counting
  // ****************
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pre_cnt_q <= '0;
      mod_cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else if (i_clock_en) begin
      tick_q <= 1'b0;
      if (rti.restart || rti.prescale == 3'h0) begin
        pre_cnt_q <= '0;
        mod_cnt_q <= 4'h0;
      end else if (!rti.hold && rti.osc_tick) begin
        if (pre_last) begin
          pre_cnt_q <= '0;
          if (mod_cnt_q == rti.modulus) begin
            mod_cnt_q <= 4'h0;
            tick_q <= 1'b1;
          end else begin
            mod_cnt_q <= mod_cnt_q + 4'h1;
          end
        end else begin
          pre_cnt_q <= pre_cnt_q + PRE_W'(1);
        end
      end
    end
  end

  // ****************
  // checks
  // ****************
  restart_clears_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && rti.restart) |=> (pre_cnt_q == '0 && mod_cnt_q == 4'h0))
    else $error("rate write did not reinitialise the divider");

  hold_freezes_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && rti.hold && !rti.restart && rti.prescale != 3'h0)
      |=> (pre_cnt_q == $past(pre_cnt_q) && mod_cnt_q == $past(mod_cnt_q)))
    else $error("divider moved while held in pseudo-stop");

  off_no_tick_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && rti.prescale == 3'h0) |=> !tick_q)
    else $error("periodic tick while prescale is off");

endmodule : plc_rti_divider
`default_nettype wire

/* hdl/plc_pll_control.sv */
// pll control and periodic rate registers of the clock generator
// assumes mode inputs come from logic on i_clock; oscillator is a pin
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - bit 7 enables clock monitor; writes ignored during self-clock mode
// - enabled monitor sees slow oscillator, starts reset or self-clock mode
// - in full stop without pseudo-stop the monitor is inactive
// - bit 6 powers pll; writes ignored while pll clock is selected
// - self-clock mode forces pll on; reads still return latched bit
// - pll on with automatic bandwidth locks without software help
// - bit 5 lets hardware pick bandwidth; writes ignored while halt-in-wait
// - manual bandwidth follows the wide filter bit; automatic ignores it
// - bit 4 picks wide (1) or narrow (0) filter, writable anytime
// - bit 2 keeps periodic timer running in pseudo-stop, else it freezes
// - bit 1 keeps watchdog running in pseudo-stop, else it freezes
// - bit 0 writable once in normal modes; never cleared in self-clock
// - clock failure enters self-clock mode if bit 0 set, else reset
// - rate write restarts divider; registers readable, rate writable anytime
// - prescale field 000 stops timer; 001..111 give two^10..two^16
// - modulus field divides by value plus one, multiplied with prescale
// - periodic divider counts oscillator clock cycles
// - halt-in-wait holds automatic bandwidth bit at one
// - pseudo-stop keeps oscillator running in stop, reduced amplitude
module plc_pll_control #(
  parameter int MON_TIMEOUT = plc_pkg::MON_TIMEOUT_CYC
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clock_en,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic i_self_clock_active,
  input wire logic i_pll_clock_select,
  input wire logic i_pll_halt_in_wait,
  input wire logic i_pseudo_stop_select,
  input wire logic i_stop_mode,
  input wire logic i_special_mode,
  input wire logic i_freq_far,
  input wire logic i_oscillator_clock,
  output logic o_pll_power,
  output logic o_pll_auto_lock,
  output logic o_wide_filter,
  output logic o_clock_monitor_active,
  output logic o_monitor_reset_req,
  output logic o_self_clock_req,
  output logic o_rti_flag_set,
  output logic o_rti_running,
  output logic o_watchdog_run,
  output logic o_osc_keep_running,
  output logic o_osc_low_amplitude
);

  if (MON_TIMEOUT < 2 || MON_TIMEOUT > 65535) begin : g_chk
    $error("monitor timeout must lie between 2 and 65535 cycles");
  end

  // ****************
  // declarations
  // ****************
  logic cme_q;
  logic pll_power_on_q;
  logic auto_q;
  logic acq_q;
  logic pre_q;
  logic pce_q;
  logic self_clock_on_fail_enable_q;
  logic self_clock_on_fail_enable_once_q;
  logic [6:0] rate_q;
  logic wr_pll;
  logic wr_rate;
  logic pstop_active;
  logic mon_active;
  logic fail_now;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic osc_lvl_q;
  logic osc_tick_q;
  logic [15:0] miss_cnt_q;
  plc_pkg::plc_mon_e mon_q;
  plc_pkg::plc_mon_e mon_d;
  plc_rti_if rti ();

  assign wr_pll = i_write && (i_addr == plc_pkg::PLL_CTRL_OFS);
  assign wr_rate = i_write && (i_addr == plc_pkg::RATE_CTRL_OFS);
  assign pstop_active = i_stop_mode && i_pseudo_stop_select;
  // full stop without pseudo-stop silences the monitor
  assign mon_active = cme_q && !(i_stop_mode && !i_pseudo_stop_select);

  // ****************
  // pll control register
  // ****************
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cme_q <= plc_pkg::PLL_CTRL_RST[plc_pkg::CME_BIT];
    end else if (i_clock_en && wr_pll && !i_self_clock_active) begin
      cme_q <= i_wdata[plc_pkg::CME_BIT];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pll_power_on_q <= plc_pkg::PLL_CTRL_RST[plc_pkg::PLL_POWER_ON_BIT];
    end else if (i_clock_en && wr_pll && !i_pll_clock_select) begin
      pll_power_on_q <= i_wdata[plc_pkg::PLL_POWER_ON_BIT];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      auto_q <= plc_pkg::PLL_CTRL_RST[plc_pkg::AUTO_BIT];
    end else if (i_clock_en) begin
      if (i_pll_halt_in_wait) begin
        auto_q <= 1'b1;
      end else if (wr_pll) begin
        auto_q <= i_wdata[plc_pkg::AUTO_BIT];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      acq_q <= plc_pkg::PLL_CTRL_RST[plc_pkg::ACQ_BIT];
      pre_q <= plc_pkg::PLL_CTRL_RST[plc_pkg::PRE_BIT];
      pce_q <= plc_pkg::PLL_CTRL_RST[plc_pkg::PCE_BIT];
    end else if (i_clock_en && wr_pll) begin
      acq_q <= i_wdata[plc_pkg::ACQ_BIT];
      pre_q <= i_wdata[plc_pkg::PRE_BIT];
      pce_q <= i_wdata[plc_pkg::PCE_BIT];
    end
  end

  // once-only lock opens again only in special modes
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      self_clock_on_fail_enable_q <= plc_pkg::PLL_CTRL_RST[plc_pkg::SELF_CLOCK_ON_FAIL_ENABLE_BIT];
      self_clock_on_fail_enable_once_q <= 1'b0;
    end else if (i_clock_en && wr_pll && (i_special_mode || !self_clock_on_fail_enable_once_q)) begin
      if (!(i_self_clock_active && !i_wdata[plc_pkg::SELF_CLOCK_ON_FAIL_ENABLE_BIT])) begin
        self_clock_on_fail_enable_q <= i_wdata[plc_pkg::SELF_CLOCK_ON_FAIL_ENABLE_BIT];
      end
      self_clock_on_fail_enable_once_q <= !i_special_mode;
    end
  end

  // ****************
  // periodic rate register
  // ****************
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      rate_q <= plc_pkg::RATE_CTRL_RST;
    end else if (i_clock_en && wr_rate) begin
      rate_q <= i_wdata[6:0];
    end
  end

  // ****************
  // register reads
  // ****************
  // data stand only in the cycle after the read strobe
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_clock_en) begin
      o_rdata <= 8'h00;
      if (i_read && i_addr == plc_pkg::PLL_CTRL_OFS) begin
        // latched power bit, not the forced state
        o_rdata <= {cme_q, pll_power_on_q, auto_q, acq_q, 1'b0, pre_q, pce_q, self_clock_on_fail_enable_q};
      end else if (i_read && i_addr == plc_pkg::RATE_CTRL_OFS) begin
        o_rdata <= {1'b0, rate_q};
      end
    end
  end

  // ****************
  // oscillator input
  // ****************
  // three stages; a level counts once the last two agree
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else if (i_clock_en) begin
      osc_s1_q <= i_oscillator_clock;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      osc_lvl_q <= 1'b0;
      osc_tick_q <= 1'b0;
    end else if (i_clock_en) begin
      osc_tick_q <= 1'b0;
      if (osc_s2_q == osc_s3_q) begin
        osc_lvl_q <= osc_s2_q;
        osc_tick_q <= osc_s2_q && !osc_lvl_q;
      end
    end
  end

  // ****************
  // clock monitor
  // ****************
  // limitation: oscillator must stay below a quarter of i_clock
  assign fail_now = (mon_q == plc_pkg::PLC_MON_WATCH) && mon_active &&
                    (miss_cnt_q == 16'(MON_TIMEOUT - 1)) && !osc_tick_q;

  always_comb begin
    mon_d = mon_q;
    case (mon_q)
      plc_pkg::PLC_MON_OFF: begin
        if (mon_active) begin
          mon_d = plc_pkg::PLC_MON_WATCH;
        end
      end
      plc_pkg::PLC_MON_WATCH: begin
        if (!mon_active) begin
          mon_d = plc_pkg::PLC_MON_OFF;
        end else if (fail_now) begin
          mon_d = plc_pkg::PLC_MON_FAIL;
        end
      end
      plc_pkg::PLC_MON_FAIL: begin
        // one request per loss; rearm once the oscillator returns
        if (!mon_active) begin
          mon_d = plc_pkg::PLC_MON_OFF;
        end else if (osc_tick_q) begin
          mon_d = plc_pkg::PLC_MON_WATCH;
        end
      end
      default: begin
        mon_d = plc_pkg::PLC_MON_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      mon_q <= plc_pkg::PLC_MON_OFF;
    end else if (i_clock_en) begin
      mon_q <= mon_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      miss_cnt_q <= 16'h0000;
    end else if (i_clock_en) begin
      if (osc_tick_q || mon_q != plc_pkg::PLC_MON_WATCH) begin
        miss_cnt_q <= 16'h0000;
      end else if (miss_cnt_q != 16'(MON_TIMEOUT - 1)) begin
        miss_cnt_q <= miss_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_self_clock_req <= 1'b0;
      o_monitor_reset_req <= 1'b0;
    end else if (i_clock_en) begin
      o_self_clock_req <= fail_now && self_clock_on_fail_enable_q;
      o_monitor_reset_req <= fail_now && !self_clock_on_fail_enable_q;
    end
  end

  // ****************
  // pll and mode outputs
  // ****************
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_pll_power <= 1'b0;
      o_pll_auto_lock <= 1'b0;
      o_wide_filter <= 1'b0;
      o_clock_monitor_active <= 1'b0;
      o_watchdog_run <= 1'b0;
      o_rti_running <= 1'b0;
      o_osc_keep_running <= 1'b0;
      o_osc_low_amplitude <= 1'b0;
    end else if (i_clock_en) begin
      o_pll_power <= pll_power_on_q || i_self_clock_active;
      o_pll_auto_lock <= (pll_power_on_q || i_self_clock_active) && auto_q;
      o_wide_filter <= auto_q ? i_freq_far : acq_q;
      o_clock_monitor_active <= mon_active;
      o_watchdog_run <= !(pstop_active && !pce_q);
      o_rti_running <= (rate_q[6:4] != 3'h0) && !(pstop_active && !pre_q);
      o_osc_keep_running <= !i_stop_mode || i_pseudo_stop_select;
      o_osc_low_amplitude <= pstop_active;
    end
  end

  // ****************
  // periodic divider
  // ****************
  assign rti.prescale = rate_q[plc_pkg::PRESC_LSB +: plc_pkg::PRESC_W];
  assign rti.modulus = rate_q[plc_pkg::MODUL_LSB +: plc_pkg::MODUL_W];
  assign rti.restart = wr_rate;
  assign rti.osc_tick = osc_tick_q;
  assign rti.hold = pstop_active && !pre_q;
  assign o_rti_flag_set = rti.tick;

  plc_rti_divider #(
    .PRE_W(16)
  ) u_div (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_clock_en(i_clock_en),
    .rti(rti.div)
  );

  // ****************
  // checks
  // ****************
  cme_write_lock_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && wr_pll && i_self_clock_active) |=> cme_q == $past(cme_q))
    else $error("monitor enable changed during self-clock mode");

  pll_power_on_write_lock_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && wr_pll && i_pll_clock_select) |=> pll_power_on_q == $past(pll_power_on_q))
    else $error("pll power bit changed while pll clock selected");

  pll_forced_on_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_self_clock_active) |=> o_pll_power)
    else $error("pll not forced on in self-clock mode");

  auto_held_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_pll_halt_in_wait) |=> auto_q)
    else $error("automatic bandwidth not held under halt-in-wait");

  manual_bandwidth_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && !auto_q) |=> o_wide_filter == $past(acq_q))
    else $error("manual bandwidth does not follow the filter bit");

  reserved_bit_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_read && i_addr == plc_pkg::PLL_CTRL_OFS) |=> !o_rdata[3])
    else $error("unimplemented bit read as one");

  self_clock_on_fail_enable_kept_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_self_clock_active && self_clock_on_fail_enable_q) |=> self_clock_on_fail_enable_q)
    else $error("self-clock enable cleared in self-clock mode");

  monitor_silent_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && i_stop_mode && !i_pseudo_stop_select)
      |=> !o_monitor_reset_req && !o_self_clock_req)
    else $error("clock failure reported in full stop");

  fail_route_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_clock_en && fail_now)
      |=> (o_self_clock_req == $past(self_clock_on_fail_enable_q)) && (o_monitor_reset_req == !$past(self_clock_on_fail_enable_q)))
    else $error("clock failure routed to the wrong response");

endmodule : plc_pll_control
`default_nettype wire

/* test/test_plc_pll_control.sv */
// self-checking bench for the pll control and periodic rate registers
// assumes a 25 MHz clock; the oscillator pin is made here at clock/8
`timescale 1ns/1ps
`default_nettype none
module test_plc_pll_control;
  // ****************
  // signals
  // ****************
  localparam int MON = 20;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_clock_en = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic i_self_clock_active = 1'b0;
  logic i_pll_clock_select = 1'b0;
  logic i_pll_halt_in_wait = 1'b0;
  logic i_pseudo_stop_select = 1'b0;
  logic i_stop_mode = 1'b0;
  logic i_special_mode = 1'b0;
  logic i_freq_far = 1'b0;
  logic i_oscillator_clock = 1'b0;
  logic [7:0] o_rdata;
  logic o_pll_power, o_pll_auto_lock, o_wide_filter, o_clock_monitor_active;
  logic o_monitor_reset_req, o_self_clock_req, o_rti_flag_set, o_rti_running;
  logic o_watchdog_run, o_osc_keep_running, o_osc_low_amplitude;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int evt_cyc = 0;
  logic rd_pend = 1'b0;
  logic osc_run = 1'b1;
  logic [1:0] osc_div = 2'h0;
  logic [7:0] rd_q[$];
  logic [2:0] evt_q[$];
  logic [2:0] evt_now;

  plc_pll_control #(.MON_TIMEOUT(MON)) dut_u (
    .i_clock, .i_reset_n, .i_clock_en, .i_addr, .i_wdata, .i_write, .i_read,
    .o_rdata, .i_self_clock_active, .i_pll_clock_select, .i_pll_halt_in_wait,
    .i_pseudo_stop_select, .i_stop_mode, .i_special_mode, .i_freq_far,
    .i_oscillator_clock, .o_pll_power, .o_pll_auto_lock, .o_wide_filter,
    .o_clock_monitor_active, .o_monitor_reset_req, .o_self_clock_req,
    .o_rti_flag_set, .o_rti_running, .o_watchdog_run, .o_osc_keep_running,
    .o_osc_low_amplitude
  );

  always #20 i_clock = ~i_clock;

  assign evt_now = {o_rti_flag_set, o_self_clock_req, o_monitor_reset_req};

  // oscillator pin well below clock/4, so the synchroniser sees every edge
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    rd_pend <= i_read;
    osc_div <= osc_div + 2'h1;
    if (osc_run && osc_div == 2'h3) begin
      i_oscillator_clock <= ~i_oscillator_clock;
    end
  end

  // ****************
  // result watcher
  // ****************
  always @(negedge i_clock) begin
    if (rd_pend) begin
      check("read data", 16'(o_rdata), 16'(rd_q.pop_front()));
    end else begin
      check("idle read data", 16'(o_rdata), 16'h0000);
    end
    if (o_rti_flag_set || o_self_clock_req || o_monitor_reset_req) begin
      evt_cyc = cyc;
      if (evt_q.size() == 0) begin
        check("unexpected event", 16'(evt_now), 16'h0000);
      end else begin
        check("event kind", 16'(evt_now), 16'(evt_q.pop_front()));
      end
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
  endtask : rd

  // bounded wait until the watcher has seen every noted event
  task automatic wait_evt(input int lim);
    int n;
    n = 0;
    while (evt_q.size() != 0 && n < lim) begin
      @(posedge i_clock);
      n++;
    end
    check("event missing", 16'(evt_q.size()), 16'h0000);
  endtask : wait_evt

  // registered outputs lag a register write by two edges
  task automatic settle;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
  endtask : settle

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(40 * 60000);
    err_count++;
    stop_test();
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    int t0;
    int exp_p;
    int dt;
    logic [7:0] v;
    void'($urandom(55601));
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rd(4'h6, 8'hF1);
    rd(4'h7, 8'h00);
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h00);
    wr(4'h7, 8'hFF);
    rd(4'h7, 8'h7F);
    // frozen clock enable: a write must not land
    @(posedge i_clock);
    i_clock_en <= 1'b0;
    wr(4'h7, 8'h00);
    i_clock_en <= 1'b1;
    rd(4'h7, 8'h7F);
    // clock loss with self-clock on fail still at its reset value
    evt_q.push_back(3'b010);
    osc_run <= 1'b0;
    wait_evt(200);
    repeat (40) @(posedge i_clock);
    osc_run <= 1'b1;
    repeat (30) @(posedge i_clock);
    wr(4'h6, 8'hFE);
    rd(4'h6, 8'hF6);
    wr(4'h6, 8'hFF);
    rd(4'h6, 8'hF6);
    evt_q.push_back(3'b001);
    osc_run <= 1'b0;
    wait_evt(200);
    osc_run <= 1'b1;
    repeat (30) @(posedge i_clock);
    // protected bits
    i_special_mode <= 1'b1;
    wr(4'h6, 8'hF7);
    rd(4'h6, 8'hF7);
    i_self_clock_active <= 1'b1;
    i_pll_clock_select <= 1'b1;
    i_pll_halt_in_wait <= 1'b1;
    wr(4'h6, 8'h00);
    rd(4'h6, 8'hE1);
    i_pll_clock_select <= 1'b0;
    i_pll_halt_in_wait <= 1'b0;
    wr(4'h6, 8'h00);
    rd(4'h6, 8'h81);
    settle();
    check("pll power forced", 16'(o_pll_power), 16'h0001);
    i_self_clock_active <= 1'b0;
    wr(4'h6, 8'h00);
    rd(4'h6, 8'h00);
    settle();
    check("pll power", 16'(o_pll_power), 16'h0000);
    // bandwidth selection
    wr(4'h6, 8'h50);
    settle();
    check("wide filter", 16'(o_wide_filter), 16'h0001);
    check("auto lock", 16'(o_pll_auto_lock), 16'h0000);
    wr(4'h6, 8'h40);
    settle();
    check("narrow filter", 16'(o_wide_filter), 16'h0000);
    wr(4'h6, 8'h70);
    for (int i = 0; i < 4; i++) begin
      i_freq_far <= i[0];
      settle();
      check("auto filter", 16'(o_wide_filter), 16'(i[0]));
      check("auto lock", 16'(o_pll_auto_lock), 16'h0001);
    end
    // pseudo-stop and stop combinations
    wr(4'h7, 8'h10);
    for (int i = 0; i < 16; i++) begin
      wr(4'h6, {1'b1, 4'h0, i[3], i[2], 1'b0});
      i_stop_mode <= i[1];
      i_pseudo_stop_select <= i[0];
      settle();
      check("monitor active", 16'(o_clock_monitor_active), 16'(!(i[1] && !i[0])));
      check("osc running", 16'(o_osc_keep_running), 16'(!i[1] || i[0]));
      check("osc low amplitude", 16'(o_osc_low_amplitude), 16'(i[1] && i[0]));
      check("watchdog run", 16'(o_watchdog_run), 16'(!(i[1] && i[0] && !i[2])));
      check("periodic run", 16'(o_rti_running), 16'(!(i[1] && i[0] && !i[3])));
    end
    // full stop: a lost oscillator must go unnoticed
    i_pseudo_stop_select <= 1'b0;
    osc_run <= 1'b0;
    repeat (100) @(posedge i_clock);
    osc_run <= 1'b1;
    repeat (30) @(posedge i_clock);
    i_stop_mode <= 1'b0;
    // periodic divider
    wr(4'h7, 8'h10);
    t0 = cyc;
    evt_q.push_back(3'b100);
    wait_evt(9000);
    check("period", 16'((evt_cyc - t0) > 8176 && (evt_cyc - t0) < 8208), 16'h0001);
    repeat (4000) @(posedge i_clock);
    v = 8'h10 | 8'($urandom % 2);
    wr(4'h7, v);
    t0 = cyc;
    exp_p = (int'(v[0]) + 1) * 8192;
    evt_q.push_back(3'b100);
    wait_evt(17000);
    dt = evt_cyc - t0;
    check("restart period", 16'(dt > exp_p - 16 && dt < exp_p + 16), 16'h0001);
    wr(4'h7, 8'h00);
    rd(4'h7, 8'h00);
    repeat (9000) @(posedge i_clock);
    stop_test();
  end
endmodule : test_plc_pll_control
`default_nettype wire
